// [rtl/pbh_consts.svh]
// Purpose: constants for the primary bus hold interface
// Assumes: 20 MHz sys_clk
// Notes: definitions only
`ifndef PBH_CONSTS_SVH
`define PBH_CONSTS_SVH
`define PBH_ADDR_W 24
`define PBH_DATA_W 32
`define PBH_RESET_VECTOR 24'h000000
`endif

// [rtl/pbh_pkg.sv]
// Purpose: types for the primary bus hold interface
// Assumes: nothing
// Notes: state enum only
package pbh_pkg;
    typedef enum logic [1:0] {
        PBH_IDLE = 2'b00,
        PBH_ACCESS = 2'b01,
        PBH_RELEASED = 2'b10,
        PBH_SHUTDOWN = 2'b11
    } pbh_state_t;
endpackage : pbh_pkg

// [rtl/pbh_req_if.sv]
// Purpose: request channel between core side and bus engine
// Assumes: same clock on both ends
// Notes: valid/accept handshake
`timescale 1ns/1ns
`default_nettype none
`include "pbh_consts.svh"
interface pbh_req_if;
    logic req_valid;
    logic req_read;
    logic [`PBH_ADDR_W-1:0] req_addr;
    logic [`PBH_DATA_W-1:0] req_wdata;
    logic req_accept;
    modport src (output req_valid, output req_read, output req_addr, output req_wdata,
                 input req_accept);
    modport dst (input req_valid, input req_read, input req_addr, input req_wdata,
                 output req_accept);
endinterface : pbh_req_if
`default_nettype wire

// [rtl/pbh_sync.sv]
// Purpose: two-flop synchroniser for the pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes: reset value is a parameter so low-active pins idle high
`timescale 1ns/1ns
`default_nettype none
module pbh_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pbh_sync
`default_nettype wire

// [rtl/pbh_bus.sv]
// Purpose: primary bus engine with release handshake
// Assumes: far side answers each access with ready_n low
// Notes: core requests enter through plain ports and pass an internal interface
//
// What this block does
// - direction high for reads, low for writes
// - access finishes only when the ready input is sampled asserted
// - a low release request lets any ongoing access finish first
// - while released, address, data, strobe and direction float; no new access
// - accesses held until release request goes high or ignore bit is set
// - grant driven low answering a low release request, on the same edge the bus floats
// - grant returns high when request goes high or ignore bit is set
// - held in reset while reset low; first fetch from the reset vector
// - shutdown low floats every pin until a later reset
`timescale 1ns/1ns
`default_nettype none
`include "pbh_consts.svh"
module pbh_bus #(
    parameter int ADDR_W = `PBH_ADDR_W,
    parameter int DATA_W = `PBH_DATA_W,
    parameter logic [ADDR_W-1:0] RESET_VECTOR = `PBH_RESET_VECTOR
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic core_valid,
    input wire logic core_read,
    input wire logic [ADDR_W-1:0] core_addr,
    input wire logic [DATA_W-1:0] core_wdata,
    output logic core_accept,
    output logic core_done,
    output logic [DATA_W-1:0] core_rdata,
    output logic boot_pending,
    input wire logic ignore_release_request,
    input wire logic ready_n,
    input wire logic release_req_n,
    input wire logic shutdown_float_n,
    input wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    output logic [ADDR_W-1:0] address_lines,
    output logic address_lines_oe,
    output logic access_strobe_n,
    output logic access_strobe_oe,
    output logic read_write,
    output logic read_write_oe,
    output logic bus_release_grant_n,
    output logic bus_release_grant_oe
);
    logic [2:0] pins_s;
    logic [DATA_W-1:0] data_s;
    logic ready_s;
    logic release_s;
    logic shz_s;
    // far side lifts ready only once it sees strobe high, so through the
    // synchroniser the old ready stays visible for two cycles of the next access
    logic [1:0] acc_age;
    pbh_req_if req ();
    pbh_sync #(.WIDTH(3), .INIT(3'h7)) u_sync_ctl (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d({ready_n, release_req_n, shutdown_float_n}),
        .q(pins_s)
    );
    pbh_sync #(.WIDTH(DATA_W), .INIT('0)) u_sync_data (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(data_lines_in),
        .q(data_s)
    );
    assign ready_s = !pins_s[2] && acc_age >= 2'h2;
    assign release_s = !pins_s[1] && !ignore_release_request;
    assign shz_s = !pins_s[0];
    // boot fetch from the vector is issued ahead of any core request
    assign req.req_valid = boot_pending || core_valid;
    assign req.req_read = boot_pending ? 1'b1 : core_read;
    assign req.req_addr = boot_pending ? RESET_VECTOR : core_addr;
    assign req.req_wdata = core_wdata;
    pbh_pkg::pbh_state_t state;
    pbh_pkg::pbh_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            pbh_pkg::PBH_IDLE: begin
                if (shz_s) next_state = pbh_pkg::PBH_SHUTDOWN;
                else if (release_s) next_state = pbh_pkg::PBH_RELEASED;
                else if (req.req_valid) next_state = pbh_pkg::PBH_ACCESS;
            end
            pbh_pkg::PBH_ACCESS: begin
                if (shz_s) next_state = pbh_pkg::PBH_SHUTDOWN;
                else if (ready_s) next_state = pbh_pkg::PBH_IDLE;
            end
            pbh_pkg::PBH_RELEASED: begin
                if (shz_s) next_state = pbh_pkg::PBH_SHUTDOWN;
                else if (!release_s) next_state = pbh_pkg::PBH_IDLE;
            end
            pbh_pkg::PBH_SHUTDOWN: next_state = pbh_pkg::PBH_SHUTDOWN;
            default: next_state = pbh_pkg::PBH_IDLE;
        endcase
    end
    assign req.req_accept = (state == pbh_pkg::PBH_IDLE) &&
                            (next_state == pbh_pkg::PBH_ACCESS);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) state <= pbh_pkg::PBH_IDLE;
        else state <= next_state;
    end
    // age of the running access; saturates so long waits cost nothing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_age <= 2'h0;
        end else if (req.req_accept) begin
            acc_age <= 2'h0;
        end else if (state == pbh_pkg::PBH_ACCESS && acc_age != 2'h3) begin
            acc_age <= acc_age + 2'h1;
        end
    end
    // launched access: pins held until ready, since the far side samples them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            address_lines <= '0;
            data_lines_out <= '0;
            read_write <= 1'b1;
        end else if (req.req_accept) begin
            address_lines <= req.req_addr;
            data_lines_out <= req.req_wdata;
            read_write <= req.req_read;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            access_strobe_n <= 1'b1;
            access_strobe_oe <= 1'b0;
            address_lines_oe <= 1'b0;
            read_write_oe <= 1'b0;
            data_lines_oe <= 1'b0;
            bus_release_grant_n <= 1'b1;
            bus_release_grant_oe <= 1'b0;
        end else begin
            access_strobe_n <= !(next_state == pbh_pkg::PBH_ACCESS);
            access_strobe_oe <= next_state != pbh_pkg::PBH_RELEASED &&
                                next_state != pbh_pkg::PBH_SHUTDOWN;
            address_lines_oe <= next_state != pbh_pkg::PBH_RELEASED &&
                                next_state != pbh_pkg::PBH_SHUTDOWN;
            read_write_oe <= next_state != pbh_pkg::PBH_RELEASED &&
                             next_state != pbh_pkg::PBH_SHUTDOWN;
            data_lines_oe <= next_state == pbh_pkg::PBH_ACCESS &&
                             (req.req_accept ? !req.req_read : !read_write);
            bus_release_grant_n <= next_state != pbh_pkg::PBH_RELEASED;
            bus_release_grant_oe <= next_state != pbh_pkg::PBH_SHUTDOWN;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_done <= 1'b0;
            core_rdata <= '0;
            core_accept <= 1'b0;
        end else begin
            core_accept <= req.req_accept && !boot_pending;
            core_done <= state == pbh_pkg::PBH_ACCESS && ready_s && !shz_s;
            if (state == pbh_pkg::PBH_ACCESS && ready_s && read_write) core_rdata <= data_s;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) boot_pending <= 1'b1;
        else if (req.req_accept) boot_pending <= 1'b0;
    end
    a_rw_stable_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!access_strobe_n && $past(!access_strobe_n) && state == pbh_pkg::PBH_ACCESS)
        |-> $stable(address_lines) && $stable(read_write))
        else $error("address or direction moved during access");
    a_no_access_released: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !bus_release_grant_n |-> access_strobe_n && !address_lines_oe && !data_lines_oe)
        else $error("bus driven while released");
    a_grant_floats_bus: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(bus_release_grant_n) |-> !access_strobe_oe && !read_write_oe)
        else $error("grant low with bus lines driven");
    a_grant_return: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pbh_pkg::PBH_RELEASED && !release_s && !shz_s) |=> bus_release_grant_n)
        else $error("grant stayed low after release ended");
    a_finish_before_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pbh_pkg::PBH_ACCESS && !ready_s && !shz_s) |=> !access_strobe_n)
        else $error("access dropped before ready");
    a_ready_ends_access: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pbh_pkg::PBH_ACCESS && ready_s && !shz_s) |=> core_done ##1 !core_done)
        else $error("ready did not complete access");
    a_write_drives_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!access_strobe_n && access_strobe_oe) |-> (data_lines_oe == !read_write))
        else $error("data drive disagrees with direction");
    a_hold_waits: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pbh_pkg::PBH_RELEASED && release_s) |=> !req.req_accept)
        else $error("access started while released");
    a_shutdown_floats: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pbh_pkg::PBH_SHUTDOWN) |-> ##1 (!bus_release_grant_oe && !address_lines_oe
        && !access_strobe_oe && !data_lines_oe && !read_write_oe))
        else $error("pins driven in shutdown");
    a_boot_vector: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (boot_pending && req.req_accept) |=> address_lines == RESET_VECTOR && read_write)
        else $error("first fetch not from reset vector");
    // a ready left over from the previous access must not end this one
    a_ready_settle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pbh_pkg::PBH_ACCESS && acc_age < 2'h2 && !shz_s) |=> !access_strobe_n)
        else $error("access ended on a stale ready");
    a_read_no_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pbh_pkg::PBH_ACCESS && read_write) |-> !data_lines_oe)
        else $error("data driven during a read");
    a_accept_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
        core_accept |=> !core_accept)
        else $error("accept pulse longer than one cycle");
    a_grant_oe_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (next_state != pbh_pkg::PBH_SHUTDOWN) |=> bus_release_grant_oe)
        else $error("grant floated outside shutdown");
    a_rdata_on_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(core_rdata) |-> core_done)
        else $error("read data moved without a finished access");
endmodule : pbh_bus
`default_nettype wire

// [verif/pbh_mem_model.sv]
// Purpose: far-side memory answering bus accesses
// Assumes: resolved strobe, high when floated
// Notes: read data is {8'ha5, address}; idle data toggles
`timescale 1ns/1ns
`default_nettype none
module pbh_mem_model (
    input wire logic sys_clk,
    input wire logic [3:0] wait_cyc,
    input wire logic access_strobe_n,
    input wire logic read_write,
    input wire logic [23:0] address_lines,
    input wire logic [31:0] data_lines_out,
    output logic ready_n,
    output logic [31:0] data_lines_in,
    output logic [31:0] last_wdata
);
    logic [3:0] cnt = 4'h0;
    initial ready_n = 1'b1;
    initial data_lines_in = 32'h0;
    initial last_wdata = 32'h0;
    always @(posedge sys_clk) begin
        if (access_strobe_n) begin
            cnt <= 4'h0;
            ready_n <= 1'b1;
            // undriven data must not look like a stale word
            data_lines_in <= ~data_lines_in;
        end else if (cnt >= wait_cyc) begin
            ready_n <= 1'b0;
            if (read_write) data_lines_in <= {8'ha5, address_lines};
            else last_wdata <= data_lines_out;
        end else cnt <= cnt + 4'h1;
    end
endmodule : pbh_mem_model
`default_nettype wire

// [verif/tb_primary_bus_hold_interface.sv]
// Purpose: self-checking bench for the bus engine
// Assumes: inputs change on the falling edge
// Notes: vector moved off zero so a stuck address shows
`timescale 1ns/1ns
`default_nettype none
module tb_primary_bus_hold_interface;
    localparam logic [23:0] VEC = 24'h000100;
    logic sys_clk = 1'b0, rst_n = 1'b0, core_valid = 1'b0, core_read = 1'b0;
    logic ignore_release_request = 1'b0, release_req_n = 1'b1, shutdown_float_n = 1'b1;
    logic [23:0] core_addr = 24'h0;
    logic [31:0] core_wdata = 32'h0;
    logic [3:0] wait_cyc = 4'h0;
    logic core_accept, core_done, boot_pending, ready_n, data_lines_oe, address_lines_oe;
    logic access_strobe_n, access_strobe_oe, read_write, read_write_oe;
    logic bus_release_grant_n, bus_release_grant_oe;
    logic [31:0] core_rdata, data_lines_in, data_lines_out, last_wdata;
    logic [23:0] address_lines;
    int error_cnt = 0, tests_run = 0;
    pbh_bus #(.RESET_VECTOR(VEC)) uut (.sys_clk, .rst_n, .core_valid, .core_read,
        .core_addr, .core_wdata, .core_accept, .core_done, .core_rdata, .boot_pending,
        .ignore_release_request, .ready_n, .release_req_n, .shutdown_float_n,
        .data_lines_in, .data_lines_out, .data_lines_oe, .address_lines, .address_lines_oe,
        .access_strobe_n, .access_strobe_oe, .read_write, .read_write_oe,
        .bus_release_grant_n, .bus_release_grant_oe);
    pbh_mem_model mem (.sys_clk, .wait_cyc, .access_strobe_n(access_strobe_n | ~access_strobe_oe),
        .read_write, .address_lines, .data_lines_out, .ready_n, .data_lines_in, .last_wdata);
    initial forever #25 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("errors=%0d tests=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic clk(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : clk
    task automatic wait_done;
        int n = 0;
        do begin clk(1); n++; end while (core_done !== 1'b1 && n < 60);
        check(core_done, 1'b1);
    endtask : wait_done
    task automatic access(input logic rd, input logic [23:0] a, input logic [31:0] d);
        int n = 0;
        core_read = rd;
        core_addr = a;
        core_wdata = d;
        core_valid = 1'b1;
        do begin clk(1); n++; end while (core_accept !== 1'b1 && n < 40);
        check({access_strobe_n, read_write, address_lines}, {1'b0, rd, a});
        core_valid = 1'b0;
        do begin
            clk(1);
            n++;
            if (core_done !== 1'b1) check({access_strobe_n, address_lines}, {1'b0, a});
        end while (core_done !== 1'b1 && n < 100);
        check(core_done, 1'b1);
        if (rd) check(core_rdata, {8'ha5, a});
        else check(last_wdata, d);
    endtask : access
    task automatic reset_boot;
        int n = 0;
        rst_n = 1'b0;
        clk(3);
        check(address_lines_oe, 1'b0);
        check(boot_pending, 1'b1);
        rst_n = 1'b1;
        do begin clk(1); n++; end while (access_strobe_n !== 1'b0 && n < 10);
        check({read_write, address_lines}, {1'b1, VEC});
        wait_done();
        check(core_rdata, {8'ha5, VEC});
        check(boot_pending, 1'b0);
    endtask : reset_boot
    task automatic t_release;
        wait_cyc = 4'h6;
        fork
            access(1'b1, 24'h00abc0, 32'h0);
            begin clk(3); release_req_n = 1'b0; clk(3); check(bus_release_grant_n, 1'b1); end
        join
        clk(5);
        check({bus_release_grant_n, bus_release_grant_oe, address_lines_oe, data_lines_oe,
               access_strobe_oe, read_write_oe}, 6'h10);
        fork
            access(1'b0, 24'hfffffc, 32'h5a5a_0ff0);
            begin clk(8); check(access_strobe_oe, 1'b0); ignore_release_request = 1'b1; end
        join
        check(bus_release_grant_n, 1'b1);
        ignore_release_request = 1'b0;
        clk(6);
        check(bus_release_grant_n, 1'b0);
        release_req_n = 1'b1;
        clk(6);
        check({bus_release_grant_n, address_lines_oe}, 2'h3);
    endtask : t_release
    task automatic t_shutdown;
        shutdown_float_n = 1'b0;
        clk(4);
        shutdown_float_n = 1'b1;
        clk(4);
        check({bus_release_grant_oe, address_lines_oe, data_lines_oe, access_strobe_oe,
               read_write_oe}, 5'h0);
        reset_boot();
    endtask : t_shutdown
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        reset_boot();
        access(1'b0, 24'h000004, 32'hdead_beef);
        access(1'b1, 24'h000008, 32'h0);
        wait_cyc = 4'h3;
        access(1'b1, 24'h800000, 32'h0);
        t_release();
        t_shutdown();
        give_verdict();
    end
endmodule : tb_primary_bus_hold_interface
`default_nettype wire
